/* File: design/rpac_pkg.sv */
// constants, field layout and tables of the record path control block
// assumes a 40 MHz system clock and a single clock domain
package rpac_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int SW     = 24;
	localparam int HW     = 26;
	localparam int APB_AW = 18;

	localparam logic signed [SW-1:0] SAMPLE_MAX = 24'h7FFFFF;
	localparam logic signed [SW-1:0] SAMPLE_MIN = 24'h800000;

	// ****************************************************************
	// register indices, byte address is four times the index
	// ****************************************************************
	localparam logic [15:0] IDX_ORDER  = 16'h4016;
	localparam logic [15:0] IDX_SLOT   = 16'h4018;
	localparam logic [15:0] IDX_CTRL   = 16'h4019;
	localparam logic [15:0] IDX_ATTL   = 16'h401A;
	localparam logic [15:0] IDX_ATTR   = 16'h401B;
	localparam logic [15:0] IDX_STATUS = 16'h40F0;

	// ****************************************************************
	// reset values and field positions
	// ****************************************************************
	localparam logic [1:0] SLOT_RST  = 2'h0;
	localparam logic [6:0] CTRL_RST  = 7'h00;
	localparam logic [7:0] ATT_RST   = 8'h00;
	localparam logic       ORDER_RST = 1'b0;

	localparam int ORDER_BIT = 4;
	localparam int CTRL_INV  = 6;
	localparam int CTRL_HPF  = 5;
	localparam int CTRL_PPOL = 4;
	localparam int CTRL_SWAP = 3;
	localparam int CTRL_DMIC = 2;
	localparam int CTRL_ENR  = 1;
	localparam int CTRL_ENL  = 0;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_HZ    = 40_000_000;
	localparam int FS_HZ       = 48_000;
	localparam int DMIC_OSR    = 128;
	localparam int BCLK_HALF   = (CLOCK_HZ + 2 * DMIC_OSR * FS_HZ - 1) / (2 * DMIC_OSR * FS_HZ);
	localparam logic [2:0] BCLK_HALF_LAST = 3'(BCLK_HALF - 1);
	localparam logic [7:0] DMIC_LAST      = 8'(DMIC_OSR - 1);
	localparam logic [4:0] SAMPLE_BITS    = 5'h18;
	localparam logic [4:0] SAMPLE_MSB     = 5'h17;

	// ****************************************************************
	// filter and gain
	// ****************************************************************
	localparam int HPF_SHIFT = 12;
	localparam logic [SW-1:0] PDM_MID = 24'h400000;
	localparam logic [16:0] GAIN_MANT [16] = '{
		17'h08000, 17'h07A97, 17'h0756A, 17'h07075, 17'h06BB5, 17'h06728, 17'h062CD, 17'h05EA1,
		17'h05A9E, 17'h056CA, 17'h05320, 17'h04F9D, 17'h04C40, 17'h04908, 17'h045F2, 17'h042FE
	};

endpackage : rpac_pkg

/* File: design/rpac_chan_if.sv */
// per channel carrier between the record path top and its sample processors
// assumes one clock domain on both ends
`timescale 1ns/10ps
`default_nettype none
interface rpac_chan_if;
	import rpac_pkg::*;
	logic signed [SW-1:0] sample;
	logic                 valid;
	logic                 invert;
	logic                 hpfEn;
	logic [7:0]           target;
	logic                 frameTick;
	logic signed [SW-1:0] result;
	logic                 resultValid;
	logic [7:0]           applied;
	modport proc (input sample, valid, invert, hpfEn, target, frameTick,
		output result, resultValid, applied);
	modport ctrl (output sample, valid, invert, hpfEn, target, frameTick,
		input result, resultValid, applied);
endinterface : rpac_chan_if
`default_nettype wire

/* File: design/rpac_chan_proc.sv */
// one channel of the record path: polarity, high-pass and slewed attenuation
// assumes a frame tick once per audio frame and sample strobes from the same clock
`timescale 1ns/10ps
`default_nettype none
module rpac_chan_proc (
	// clock and reset
	input wire logic    clock,
	input wire logic    rst_n,
	// channel carrier
	rpac_chan_if.proc   ch
);
	import rpac_pkg::*;

	logic signed [SW-1:0]   prevIn_q;
	logic signed [HW-1:0]   hpfOut_q;
	logic signed [SW-1:0]   stage_q;
	logic                   stageValid_q;
	logic [7:0]             applied_q;
	logic signed [SW-1:0]   result_q;
	logic                   resultValid_q;

	// ****************************************************************
	// polarity and high-pass
	// ****************************************************************
	// the most negative code has no positive twin, so it clips
	wire signed [SW-1:0] polIn = !ch.invert ? ch.sample :
		(ch.sample == SAMPLE_MIN) ? SAMPLE_MAX : -ch.sample;
	// one pole dc blocker, pole tied to the sample rate so the corner tracks fs
	wire signed [HW-1:0] hpfNext = HW'(polIn) - HW'(prevIn_q) + hpfOut_q
		- (hpfOut_q >>> HPF_SHIFT);
	wire hpfPos = !hpfNext[HW-1] && (hpfNext[HW-2:SW-1] != 2'h0);
	wire hpfNeg = hpfNext[HW-1] && (hpfNext[HW-2:SW-1] != 2'h3);
	wire signed [SW-1:0] hpfSat = hpfPos ? SAMPLE_MAX : hpfNeg ? SAMPLE_MIN : hpfNext[SW-1:0];
	wire signed [SW-1:0] stageIn = ch.hpfEn ? hpfSat : polIn;

	// ****************************************************************
	// attenuation: mantissa table times an octave shift
	// ****************************************************************
	wire [16:0] mant = GAIN_MANT[applied_q[3:0]];
	wire signed [SW+17:0] prod = stage_q * $signed({1'b0, mant});
	wire signed [SW+17:0] scaled = prod >>> (5'h0F + {1'b0, applied_q[7:4]});

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prevIn_q <= '0;
			hpfOut_q <= '0;
			stage_q <= '0;
			stageValid_q <= 1'b0;
			result_q <= '0;
			resultValid_q <= 1'b0;
		end else begin
			stageValid_q <= ch.valid;
			resultValid_q <= stageValid_q;
			if (ch.valid) begin
				stage_q <= stageIn;
				prevIn_q <= ch.hpfEn ? polIn : '0;
				hpfOut_q <= ch.hpfEn ? hpfNext : '0;
			end
			if (stageValid_q) begin
				result_q <= scaled[SW-1:0];
			end
		end
	end

	// one step per frame toward the target, never a jump
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			applied_q <= ATT_RST;
		end else if (ch.frameTick && applied_q < ch.target) begin
			applied_q <= applied_q + 8'h01;
		end else if (ch.frameTick && applied_q > ch.target) begin
			applied_q <= applied_q - 8'h01;
		end
	end

	assign ch.result = result_q;
	assign ch.resultValid = resultValid_q;
	assign ch.applied = applied_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_slew_single: assert property ((applied_q != $past(applied_q)) |->
		$past(ch.frameTick) && ((applied_q - $past(applied_q) == 8'h01) ||
		($past(applied_q) - applied_q == 8'h01)))
		else $error("attenuator moved without a frame or by more than one step");
	a_slew_up: assert property (ch.frameTick && applied_q < ch.target |=>
		applied_q == $past(applied_q) + 8'h01)
		else $error("attenuator did not step toward a larger target");
	a_reset_unity: assert property ($past(!rst_n) |-> applied_q == 8'h00)
		else $error("attenuator not at 0 dB after reset");
	a_invert_sign: assert property (ch.valid && ch.invert && !ch.hpfEn &&
		ch.sample != SAMPLE_MIN |=> stage_q == -$past(ch.sample))
		else $error("inverted sample is not the negated input");
	// every sixteen steps halve the sample exactly, so whole octaves need no rounding
	a_gain_steps: assert property (stageValid_q && applied_q[3:0] == 4'h0 |=>
		result_q == ($past(stage_q) >>> $past(applied_q[7:4])))
		else $error("sixteen steps do not halve the sample");
	a_gain_unity: assert property (stageValid_q && applied_q == 8'h00 |=>
		result_q == $past(stage_q))
		else $error("0 dB setting changed the sample");
	c_slewing: cover property (ch.frameTick && applied_q != ch.target);

endmodule : rpac_chan_proc
`default_nettype wire

/* File: design/rpac_pdm_capture.sv */
// stereo pdm capture with pulse counting decimation over one frame
// assumes the data bit is already synchronised and edges come as one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module rpac_pdm_capture (
	// clock and reset
	input wire logic                       clock,
	input wire logic                       rst_n,
	// bit stream
	input wire logic                       pdmBit,
	input wire logic                       bitRise,
	input wire logic                       bitFall,
	input wire logic                       frameTick,
	// configuration
	input wire logic                       polarity,
	input wire logic                       swap,
	// decimated samples
	output logic signed [rpac_pkg::SW-1:0] leftSample,
	output logic signed [rpac_pkg::SW-1:0] rightSample,
	output logic                           sampleValid
);
	import rpac_pkg::*;

	logic [7:0] leftCnt_q;
	logic [7:0] rightCnt_q;

	wire pulse     = polarity ? pdmBit : ~pdmBit;
	wire leftEdge  = swap ? bitFall : bitRise;
	wire rightEdge = swap ? bitRise : bitFall;

	// a boxcar over one frame is crude but needs no multiplier
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			leftCnt_q <= 8'h00;
			rightCnt_q <= 8'h00;
			leftSample <= '0;
			rightSample <= '0;
			sampleValid <= 1'b0;
		end else begin
			sampleValid <= frameTick;
			if (frameTick) begin
				leftSample <= $signed({leftCnt_q, 16'h0000} - PDM_MID);
				rightSample <= $signed({rightCnt_q, 16'h0000} - PDM_MID);
				leftCnt_q <= 8'h00;
				rightCnt_q <= 8'h00;
			end else begin
				if (leftEdge && pulse) begin
					leftCnt_q <= leftCnt_q + 8'h01;
				end
				if (rightEdge && pulse) begin
					rightCnt_q <= rightCnt_q + 8'h01;
				end
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_pdm_left: assert property (!frameTick && bitRise && !swap && (pdmBit == polarity) |=>
		leftCnt_q == $past(leftCnt_q) + 8'h01)
		else $error("active pdm level on rising edge not counted for left");
	a_pdm_swap: assert property (!frameTick && bitRise && !bitFall && swap |=>
		leftCnt_q == $past(leftCnt_q))
		else $error("swapped mode counted left on the rising edge");

endmodule : rpac_pdm_capture
`default_nettype wire

/* File: design/rpac_record_path.sv */
// record path control top: apb registers, source select, tdm serializer
// assumes apb on the system clock; bit and frame clocks arrive asynchronously
//
// What this block does
// - slot code picks which TDM pair carries record
// - order bit puts left or right first
// - invert bit negates record samples
// - optional high-pass with corner tracking sample rate
// - pdm polarity picks which level is pulse
// - left on rising edge, swap exchanges edges
// - digital mic: ADCs off, bit clock driven
// - two enable bits switch ADC channels individually
// - 256-step 0.375 dB log attenuator per channel
// - attenuation slews one step per frame
// - independent attenuators reset to 0 dB
`timescale 1ns/10ps
`default_nettype none
module rpac_record_path (
	// clock and reset
	input wire logic                            clock,
	input wire logic                            rst_n,
	// apb slave
	input wire logic [rpac_pkg::APB_AW-1:0]     paddr,
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pwrite,
	input wire logic [31:0]                     pwdata,
	output logic [31:0]                         prdata,
	output logic                                pready,
	output logic                                pslverr,
	// on-chip converters
	input wire logic signed [rpac_pkg::SW-1:0]  adcLeft,
	input wire logic signed [rpac_pkg::SW-1:0]  adcRight,
	input wire logic                            adcValid,
	output logic                                adcPowerLeft,
	output logic                                adcPowerRight,
	// serial audio port pins
	input wire logic                            bitClockIn,
	output logic                                bitClockOut,
	output logic                                bitClockOe,
	input wire logic                            frameClockIn,
	input wire logic                            recordSerialDataIn,
	output logic                                recordSerialDataOut,
	output logic                                recordSerialDataOe,
	// processed record samples
	output logic signed [rpac_pkg::SW-1:0]      recLeft,
	output logic signed [rpac_pkg::SW-1:0]      recRight,
	output logic                                recValid
);
	import rpac_pkg::*;

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [1:0]  slotSel_q;
	logic [6:0]  ctrl_q;
	logic [7:0]  attL_q;
	logic [7:0]  attR_q;
	logic        order_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;

	wire        setup   = psel && !penable;
	wire [15:0] regIdx  = paddr[APB_AW-1:2];
	wire        aligned = (paddr[1:0] == 2'h0);
	wire        hitOrd  = aligned && (regIdx == IDX_ORDER);
	wire        hitSlot = aligned && (regIdx == IDX_SLOT);
	wire        hitCtrl = aligned && (regIdx == IDX_CTRL);
	wire        hitAttL = aligned && (regIdx == IDX_ATTL);
	wire        hitAttR = aligned && (regIdx == IDX_ATTR);
	wire        hitStat = aligned && (regIdx == IDX_STATUS);
	wire        mapped  = hitOrd || hitSlot || hitCtrl || hitAttL || hitAttR || hitStat;
	wire        wrEn    = psel && penable && pready_q && pwrite && mapped;
	wire [7:0]  appliedL;
	wire [7:0]  appliedR;
	wire [31:0] rdValue = hitOrd  ? {27'h0000000, order_q, 4'h0} :
		hitSlot ? {30'h00000000, slotSel_q} :
		hitCtrl ? {25'h0000000, ctrl_q} :
		hitAttL ? {24'h000000, attL_q} :
		hitAttR ? {24'h000000, attR_q} :
		hitStat ? {16'h0000, appliedR, appliedL} : 32'h00000000;

	// answer in the cycle after setup; reserved bits read as zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q <= (setup && !pwrite) ? rdValue : prdata_q;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			slotSel_q <= SLOT_RST;
			ctrl_q <= CTRL_RST;
			attL_q <= ATT_RST;
			attR_q <= ATT_RST;
			order_q <= ORDER_RST;
		end else if (wrEn) begin
			slotSel_q <= hitSlot ? pwdata[1:0] : slotSel_q;
			ctrl_q <= hitCtrl ? pwdata[6:0] : ctrl_q;
			attL_q <= hitAttL ? pwdata[7:0] : attL_q;
			attR_q <= hitAttR ? pwdata[7:0] : attR_q;
			order_q <= hitOrd ? pwdata[ORDER_BIT] : order_q;
		end
	end

	wire dmic = ctrl_q[CTRL_DMIC];

	// ****************************************************************
	// pin synchronisers and bit clock
	// ****************************************************************
	logic [1:0] bclkSync_q;
	logic [1:0] lrSync_q;
	logic [1:0] rsdSync_q;
	logic       bclkPrev_q;
	logic       lrPrev_q;
	logic [2:0] div_q;
	logic       bclkGen_q;
	logic       bclkOe_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bclkSync_q <= 2'h0;
			lrSync_q <= 2'h0;
			rsdSync_q <= 2'h0;
			bclkPrev_q <= 1'b0;
			lrPrev_q <= 1'b0;
		end else begin
			bclkSync_q <= {bclkSync_q[0], bitClockIn};
			lrSync_q <= {lrSync_q[0], frameClockIn};
			rsdSync_q <= {rsdSync_q[0], recordSerialDataIn};
			bclkPrev_q <= bclkSync_q[1];
			lrPrev_q <= lrSync_q[1];
		end
	end

	// integer divider rounds up, so the mic clock never exceeds its target rate
	wire divWrap = (div_q == BCLK_HALF_LAST);
	always_ff @(posedge clock) begin
		if (!rst_n || !dmic) begin
			div_q <= 3'h0;
			bclkGen_q <= 1'b0;
		end else if (divWrap) begin
			div_q <= 3'h0;
			bclkGen_q <= ~bclkGen_q;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bclkOe_q <= 1'b0;
		end else begin
			bclkOe_q <= dmic;
		end
	end

	wire bitRise = dmic ? (divWrap && !bclkGen_q) : (bclkSync_q[1] && !bclkPrev_q);
	wire bitFall = dmic ? (divWrap && bclkGen_q) : (!bclkSync_q[1] && bclkPrev_q);

	// ****************************************************************
	// frame timing
	// ****************************************************************
	logic [7:0] bitCnt_q;
	wire frameTick = dmic ? (bitFall && bitCnt_q == DMIC_LAST) : (lrSync_q[1] && !lrPrev_q);

	always_ff @(posedge clock) begin
		if (!rst_n || frameTick) begin
			bitCnt_q <= 8'h00;
		end else if (bitFall) begin
			bitCnt_q <= bitCnt_q + 8'h01;
		end
	end

	// ****************************************************************
	// source select and channel processing
	// ****************************************************************
	logic signed [SW-1:0] pdmLeft;
	logic signed [SW-1:0] pdmRight;
	logic                 pdmValid;

	rpac_pdm_capture u_pdm (
		.clock       (clock),
		.rst_n       (rst_n),
		.pdmBit      (rsdSync_q[1]),
		.bitRise     (bitRise),
		.bitFall     (bitFall),
		.frameTick   (frameTick && dmic),
		.polarity    (ctrl_q[CTRL_PPOL]),
		.swap        (ctrl_q[CTRL_SWAP]),
		.leftSample  (pdmLeft),
		.rightSample (pdmRight),
		.sampleValid (pdmValid)
	);

	wire signed [SW-1:0] adcIn [2];
	wire signed [SW-1:0] pdmIn [2];
	wire [7:0]           attIn [2];
	wire [1:0]           enIn = {ctrl_q[CTRL_ENR], ctrl_q[CTRL_ENL]};
	wire signed [SW-1:0] resultOut [2];
	wire [7:0]           appliedOut [2];
	wire                 resultValidL;

	assign adcIn[0] = adcLeft;
	assign adcIn[1] = adcRight;
	assign pdmIn[0] = pdmLeft;
	assign pdmIn[1] = pdmRight;
	assign attIn[0] = attL_q;
	assign attIn[1] = attR_q;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		rpac_chan_if chIf ();
		// an ADC channel that is switched off feeds silence
		assign chIf.sample = dmic ? pdmIn[c] : (enIn[c] ? adcIn[c] : '0);
		assign chIf.valid = dmic ? pdmValid : adcValid;
		assign chIf.invert = ctrl_q[CTRL_INV];
		assign chIf.hpfEn = ctrl_q[CTRL_HPF];
		assign chIf.target = attIn[c];
		assign chIf.frameTick = frameTick;
		assign resultOut[c] = chIf.result;
		assign appliedOut[c] = chIf.applied;
		rpac_chan_proc u_proc (
			.clock (clock),
			.rst_n (rst_n),
			.ch    (chIf.proc)
		);
	end

	assign appliedL = appliedOut[0];
	assign appliedR = appliedOut[1];
	assign resultValidL = g_chan[0].chIf.resultValid;

	// ****************************************************************
	// tdm serializer and outputs
	// ****************************************************************
	logic signed [SW-1:0] recLeft_q;
	logic signed [SW-1:0] recRight_q;
	logic                 recValid_q;
	logic [SW-1:0]        txL_q;
	logic [SW-1:0]        txR_q;
	logic                 rsdOut_q;
	logic                 rsdOe_q;
	logic                 powerL_q;
	logic                 powerR_q;

	wire [4:0]    bitPos  = bitCnt_q[4:0];
	wire          inPair  = !dmic && (bitCnt_q[7:6] == slotSel_q) && (bitPos < SAMPLE_BITS);
	wire          chanSel = bitCnt_q[5] ^ order_q;
	wire [SW-1:0] txWord  = chanSel ? txR_q : txL_q;
	wire          txBit   = txWord[SAMPLE_MSB - bitPos];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			recLeft_q <= '0;
			recRight_q <= '0;
			recValid_q <= 1'b0;
			txL_q <= '0;
			txR_q <= '0;
			rsdOut_q <= 1'b0;
			rsdOe_q <= 1'b0;
			powerL_q <= 1'b0;
			powerR_q <= 1'b0;
		end else begin
			recValid_q <= resultValidL;
			recLeft_q <= resultValidL ? resultOut[0] : recLeft_q;
			recRight_q <= resultValidL ? resultOut[1] : recRight_q;
			// words are latched once per frame so a slot never mixes two samples
			txL_q <= frameTick ? recLeft_q : txL_q;
			txR_q <= frameTick ? recRight_q : txR_q;
			rsdOut_q <= dmic ? 1'b0 : (bitFall ? (inPair && txBit) : rsdOut_q);
			rsdOe_q <= dmic ? 1'b0 : (bitFall ? inPair : rsdOe_q);
			powerL_q <= !dmic && ctrl_q[CTRL_ENL];
			powerR_q <= !dmic && ctrl_q[CTRL_ENR];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign adcPowerLeft = powerL_q;
	assign adcPowerRight = powerR_q;
	assign bitClockOut = bclkGen_q;
	assign bitClockOe = bclkOe_q;
	assign recordSerialDataOut = rsdOut_q;
	assign recordSerialDataOe = rsdOe_q;
	assign recLeft = recLeft_q;
	assign recRight = recRight_q;
	assign recValid = recValid_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_slot_pair: assert property ($rose(rsdOe_q) |->
		$past(bitCnt_q[7:6]) == $past(slotSel_q) && $past(bitPos) == 5'h00)
		else $error("record data driven outside the selected slot pair");
	a_chan_first: assert property ($rose(rsdOe_q) && $past(bitCnt_q[5]) == 1'b0 |->
		rsdOut_q == $past(order_q ? txR_q[SW-1] : txL_q[SW-1]))
		else $error("first slot of the pair carries the wrong channel");
	a_dmic_master: assert property ($rose(dmic) |-> ##[1:2] (bitClockOe && !recordSerialDataOe
		&& !adcPowerLeft && !adcPowerRight))
		else $error("digital mic mode did not take the bit clock or power down the ADCs");
	a_adc_enable: assert property (!dmic && $past(!dmic) && $stable(ctrl_q) |->
		adcPowerLeft == ctrl_q[CTRL_ENL] && adcPowerRight == ctrl_q[CTRL_ENR])
		else $error("ADC power does not follow its enable bits");
	c_dmic_frame: cover property (dmic && frameTick);
	c_fourth_pair: cover property (rsdOe_q && slotSel_q == 2'h3);
	c_apb_write: cover property (wrEn && hitAttL);

endmodule : rpac_record_path
`default_nettype wire

/* File: tb/rpac_sap_host.sv */
// serial port host model: makes the bit and frame clocks of the record port
// assumes the device follows these clocks as a slave outside digital mic mode
`timescale 1ns/10ps
`default_nettype none
module rpac_sap_host (
	// clocks to the device
	output logic bitClock,
	output logic frameClock
);
	int n;
	// eight 32-bit slots, so every slot pair is legal
	initial begin
		bitClock = 1'b0;
		frameClock = 1'b0;
		forever begin
			for (n = 0; n < 256; n++) begin
				frameClock = (n < 128);
				#100 bitClock = 1'b1;
				#100 bitClock = 1'b0;
			end
		end
	end
endmodule : rpac_sap_host
`default_nettype wire

/* File: tb/rpac_record_path_tb.sv */
// self-checking bench of the record path block
// assumes the host model supplies bit and frame clocks
`timescale 1ns/10ps
`default_nettype none
module rpac_record_path_tb;
	import rpac_pkg::*;
	logic clock, rst_n, psel, penable, pwrite, adcValid;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, pwL, pwR, bco, bcoe, sdo, sdoe, recValid, bck, frm;
	logic signed [SW-1:0] adcLeft, adcRight, recLeft, recRight;
	int miscompares, samplesChecked, cyc;
	rpac_sap_host i_rpac_sap_host (.bitClock(bck), .frameClock(frm));
	rpac_record_path i_rpac_record_path (.clock(clock), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adcLeft(adcLeft), .adcRight(adcRight),
		.adcValid(adcValid), .adcPowerLeft(pwL), .adcPowerRight(pwR), .bitClockIn(bck),
		.bitClockOut(bco), .bitClockOe(bcoe), .frameClockIn(frm), .recordSerialDataIn(1'b0),
		.recordSerialDataOut(sdo), .recordSerialDataOe(sdoe), .recLeft(recLeft),
		.recRight(recRight), .recValid(recValid));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		samplesChecked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic summarize();
		if (miscompares == 0 && samplesChecked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	task automatic t_regs();
		apb(0, IDX_ATTL, 0); chk("attL", 0, rd);
		apb(0, IDX_ATTR, 0); chk("attR", 0, rd);
		apb(0, IDX_SLOT, 0); chk("slot", 0, rd);
		apb(1, IDX_CTRL, 32'h01);
		repeat (2) @(negedge clock);
		chk("pwr", 2'b01, {pwR, pwL});
		apb(1, IDX_CTRL, 32'h02);
		repeat (2) @(negedge clock);
		chk("pwr", 2'b10, {pwR, pwL});
		apb(0, 16'h4000, 0); chk("slverr", 1, err);
	endtask : t_regs
	task automatic t_adc(input logic [31:0] ctl, input logic [47:0] exp);
		int t;
		apb(1, IDX_CTRL, ctl);
		@(posedge clock);
		adcLeft <= 24'h000100; adcRight <= 24'h000200; adcValid <= 1'b1;
		@(posedge clock);
		adcValid <= 1'b0;
		t = 0;
		do begin @(negedge clock); t++; end while (recValid !== 1'b1 && t < 20);
		chk("rec", exp, {recLeft, recRight});
	endtask : t_adc
	// pair four with right first: bit 193 of the frame is the right word's msb
	task automatic t_tdm();
		logic [23:0] w;
		apb(1, IDX_SLOT, 32'h03);
		apb(1, IDX_ORDER, 32'h10);
		t_adc(32'h03, 48'h000100000200);
		@(posedge frm);
		repeat (193) @(posedge bck);
		for (int b = 0; b < 24; b++) begin
			@(posedge bck);
			w = {w[22:0], sdo};
			if (b == 0) chk("sdoe", 1, sdoe);
		end
		chk("tdm", 24'h000200, w);
	endtask : t_tdm
	task automatic t_slew();
		// write well clear of a frame tick so the first step is counted once
		@(posedge frm);
		repeat (10) @(posedge clock);
		apb(1, IDX_ATTL, 32'h03);
		for (int k = 1; k < 6; k++) begin
			@(posedge frm);
			repeat (10) @(posedge clock);
			apb(0, IDX_STATUS, 0);
			chk("applied", (k < 3) ? k : 3, rd[15:0]);
		end
	endtask : t_slew
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		adcLeft = '0; adcRight = '0; adcValid = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_adc(32'h03, 48'h000100000200);
		t_adc(32'h43, 48'hFFFF00FFFE00);
		t_adc(32'h01, 48'h000100000000);
		t_tdm();
		t_slew();
		apb(1, IDX_CTRL, 32'h04);
		repeat (2) @(negedge clock);
		chk("dmic", 3'b100, {bcoe, pwR, pwL});
		rd[0] = bco;
		repeat (4) @(negedge clock);
		chk("bclk", !rd[0], bco);
		summarize();
	end
	initial begin
		cyc = 0;
		forever begin
			@(posedge clock);
			cyc++;
			if (cyc == 60000) begin
				miscompares++;
				summarize();
			end
		end
	end
endmodule : rpac_record_path_tb
`default_nettype wire
